// ===== dv/asr_checker.sv
// Port-level assertions for the sample register map
`timescale 1ns/1ns
`default_nettype none

module asr_checker (
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic scl_in,
	input wire logic sda_out,
	input wire logic sda_oe_n,
	input wire logic [7:0] queue_setup,
	input wire logic [7:0] capture_trigger_map,
	input wire logic [1:0] queue_operating_mode
);
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (sys_rst);

	// ----------------------------------------
	// Data pin and register timing
	// ----------------------------------------
	// Open drain: the output value never leaves zero
	property p_od;
		sda_out == 1'b0;
	endproperty
	a_od: assert property (p_od) else $error("data output value not low");
	// Mode copy trails the setup field by exactly one cycle
	property p_qm;
		queue_operating_mode == $past(queue_setup[7:6]);
	endproperty
	a_qm: assert property (p_qm) else $error("queue mode copy wrong");
	property p_rst;
		$fell(sys_rst) |-> queue_setup == 8'h00 && capture_trigger_map == 8'h00 && sda_oe_n;
	endproperty
	a_rst: assert property (p_rst) else $error("reset values wrong");
	// A stored byte is always acknowledged
	property p_qs_ack;
		$changed(queue_setup) |-> ##[0:2] !sda_oe_n;
	endproperty
	a_qs_ack: assert property (p_qs_ack) else $error("setup change without ack");
	property p_tm_ack;
		$changed(capture_trigger_map) |-> ##[0:2] !sda_oe_n;
	endproperty
	a_tm_ack: assert property (p_tm_ack) else $error("trigger map change without ack");
	// One data byte lands in one register only
	property p_one;
		$changed(queue_setup) |-> $stable(capture_trigger_map);
	endproperty
	a_one: assert property (p_one) else $error("two registers written at once");
	property p_stand;
		$fell(sda_oe_n) |-> !sda_oe_n [*8];
	endproperty
	a_stand: assert property (p_stand) else $error("data pull too short");
	// Data may only move while the bus clock is low
	property p_scl;
		$changed(sda_oe_n) |-> !scl_in;
	endproperty
	a_scl: assert property (p_scl) else $error("data moved with clock high");
	c_qs: cover property ($changed(queue_setup));
	c_tm: cover property ($changed(capture_trigger_map));
	c_ack: cover property ($fell(sda_oe_n) ##1 !sda_oe_n);
endmodule // asr_checker

bind asr_reg_map asr_checker u_chk (
	.clock(clock),
	.sys_rst(sys_rst),
	.scl_in(scl_in),
	.sda_out(sda_out),
	.sda_oe_n(sda_oe_n),
	.queue_setup(queue_setup),
	.capture_trigger_map(capture_trigger_map),
	.queue_operating_mode(queue_operating_mode)
);

`default_nettype wire

// ===== dv/asr_host.sv
// Two-wire bus master model facing the register map
`timescale 1ns/1ns
`default_nettype none

module asr_host (
	input wire logic clock,
	input wire logic sda,
	output logic scl,
	output logic sda_m
);
	// Half period in clocks; the bench may stretch it to act slowly
	int hp = 12;
	// Bus owned between start and stop; an idle start must not pulse the clock
	bit busy = 1'b0;

	// ----------------------------------------
	// Bit-level tasks
	// ----------------------------------------
	// Both lines released at power-up, pull-ups hold them high
	initial
	begin
		scl = 1'b1;
		sda_m = 1'b1;
	end
	// One clock: a is set while low, r sampled mid-high, b set after
	task automatic cyc(input logic a, input logic b, output logic r);
		scl = 1'b0;
		repeat (hp / 2) @(negedge clock);
		sda_m = a;
		repeat (hp / 2) @(negedge clock);
		scl = 1'b1;
		repeat (hp / 2) @(negedge clock);
		r = sda;
		sda_m = b;
		repeat (hp / 2) @(negedge clock);
	endtask
	// Start and stop are data edges with the clock high
	task automatic st();
		logic r;
		if (busy)
			cyc(1'b1, 1'b0, r); // Repeated start needs a fresh clock high
		else
		begin
			repeat (hp / 2) @(negedge clock);
			sda_m = 1'b0; // Clock already high and still
			repeat (hp / 2) @(negedge clock);
		end
		busy = 1'b1;
	endtask
	task automatic sp();
		logic r;
		cyc(1'b0, 1'b1, r);
		busy = 1'b0;
	endtask
	// Byte then ninth clock; d = ff releases data to receive
	task automatic xb(input logic [7:0] d, input logic nk, output logic [7:0] q, output logic ak);
		logic r;
		for (int i = 7; i >= 0; i--)
		begin
			cyc(d[i], d[i], r);
			q[i] = r;
		end
		cyc(nk, nk, r);
		ak = !r;
	endtask
endmodule // asr_host

`default_nettype wire

// ===== dv/asr_reg_map_tb.sv
// Self-checking testbench for the sample register map
`timescale 1ns/1ns
`default_nettype none

module asr_reg_map_tb;
	logic clock = 1'b0;
	logic sys_rst = 1'b1;
	logic sel = 1'b0;
	logic fast = 1'b0;
	logic en = 1'b1;
	logic scl, sda_m, sda_out, sda_oe_n;
	logic [7:0] qs, tm;
	logic [1:0] qm;
	logic [13:0] xs = 14'h2d5a;
	logic [13:0] ys = 14'h1397;
	logic [13:0] zs = 14'h3e01;
	logic [7:0] ss = 8'h81;
	logic [7:0] fs = 8'h4c;
	int mismatches = 0;
	int cmp_count = 0;
	// Wired-and of the host and the device pull-down
	wire sda = sda_m & (sda_oe_n | sda_out);

	always #25 clock = ~clock;

	asr_host h (.clock(clock), .sda(sda), .scl(scl), .sda_m(sda_m));
	asr_reg_map dut (.clock(clock), .sys_rst(sys_rst), .clk_en(en), .scl_in(scl),
		.sda_in(sda), .sda_out(sda_out), .sda_oe_n(sda_oe_n), .address_select_input(sel),
		.fast_read_enable(fast), .x_sample(xs), .y_sample(ys), .z_sample(zs),
		.sample_status(ss), .queue_status(fs), .queue_setup(qs),
		.capture_trigger_map(tm), .queue_operating_mode(qm));

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		cmp_count++;
		if (g !== e)
		begin
			mismatches++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic summarize();
		$display("comparisons %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// Send a byte that must be acknowledged
	task automatic ab(input logic [7:0] b);
		logic [7:0] q;
		logic a;
		h.xb(b, 1'b1, q, a);
		chk({7'h00, a}, 8'h01);
	endtask
	task automatic wr(input logic [7:0] dv, input logic [7:0] ra, input logic [7:0] d[$]);
		h.st();
		ab(dv);
		ab(ra);
		foreach (d[i])
			ab(d[i]);
		h.sp();
	endtask
	// Optional pointer set and repeated start, burst read with final refusal
	task automatic rd(input logic p, input logic [7:0] ra, input logic [7:0] e[$]);
		logic [7:0] q;
		logic a;
		if (p)
		begin
			h.st();
			ab(8'h38);
			ab(ra);
		end
		h.st();
		ab(8'h39);
		foreach (e[i])
		begin
			h.xb(8'hff, i == e.size() - 1, q, a);
			chk(q, e[i]);
		end
		h.sp();
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_map();
		rd(1'b1, 8'h09, '{8'h00, 8'h00});
		// The last sample byte wraps the pointer back to status
		rd(1'b1, 8'h00, '{ss, xs[13:6], {xs[5:0], 2'b00}, ys[13:6], {ys[5:0], 2'b00},
			zs[13:6], {zs[5:0], 2'b00}, ss, xs[13:6], {xs[5:0], 2'b00},
			ys[13:6]});
		wr(8'h38, 8'h07, '{8'h5a, 8'h5a, 8'h3c, 8'ha5});
		rd(1'b1, 8'h07, '{8'h00, 8'h00, 8'h3c, 8'ha5});
		chk(tm, 8'ha5);
		chk(qs, 8'h3c);
		$display("test map done");
	endtask
	task automatic t_modes();
		wr(8'h38, 8'h09, '{8'h80});
		chk({6'h00, qm}, 8'h02);
		rd(1'b1, 8'h00, '{fs, xs[13:6], xs[13:6], xs[13:6]});
		fast = 1'b1;
		rd(1'b1, 8'h03, '{ys[13:6], fs});
		wr(8'h38, 8'h09, '{8'h00});
		rd(1'b1, 8'h01, '{xs[13:6], ys[13:6], zs[13:6], ss, xs[13:6]});
		rd(1'b1, 8'h02, '{{xs[5:0], 2'b00}, ss});
		fast = 1'b0;
		$display("test modes done");
	endtask
	task automatic t_nak();
		rd(1'b1, 8'h03, '{ys[13:6]});
		rd(1'b0, 8'h00, '{ys[13:6], {ys[5:0], 2'b00}});
		$display("test nak done");
	endtask
	task automatic t_strap();
		logic [7:0] q;
		logic a;
		h.hp = 24;
		sel = 1'b1;
		repeat (8) @(negedge clock);
		h.st();
		h.xb(8'h38, 1'b1, q, a);
		chk({7'h00, a}, 8'h00);
		h.sp();
		wr(8'h3a, 8'h0a, '{8'h66});
		chk(tm, 8'h66);
		sel = 1'b0;
		h.hp = 12;
		$display("test strap done");
	endtask
	// Frozen clock enable ignores a whole frame; a mid-run reset clears the map
	task automatic t_freeze();
		logic [7:0] q;
		logic a;
		en = 1'b0;
		h.st();
		h.xb(8'h38, 1'b1, q, a);
		chk({7'h00, a}, 8'h00);
		h.sp();
		en = 1'b1;
		repeat (4) @(negedge clock);
		rd(1'b1, 8'h0a, '{8'h66});
		sys_rst = 1'b1;
		repeat (2) @(negedge clock);
		sys_rst = 1'b0;
		repeat (6) @(negedge clock);
		chk(tm, 8'h00);
		rd(1'b1, 8'h09, '{8'h00, 8'h00});
		$display("test freeze done");
	endtask

	// Watchdog turns a hang into a counted mismatch
	initial
	begin
		repeat (90000) @(posedge clock);
		mismatches++;
		summarize();
	end
	// Main sequence
	initial
	begin
		repeat (12) @(negedge clock);
		sys_rst = 1'b0;
		repeat (6) @(negedge clock);
		t_map();
		t_modes();
		t_nak();
		t_strap();
		t_freeze();
		summarize();
	end
endmodule // asr_reg_map_tb

`default_nettype wire

// ===== hw/asr_next_addr.v
// Register pointer auto-increment target, steered by queue mode and fast read
`timescale 1ns/1ns
`default_nettype none
`include "asr_regs.vh"

module asr_next_addr (
	input wire [7:0] cur_addr,
	input wire queue_active,
	input wire fast_read,
	output reg [7:0] next_addr
);

	// Default is plain increment; the sample block wraps back to status
	always @*
	begin
		next_addr = cur_addr + 8'h01;
		case (cur_addr)
			`ASR_ADDR_X_HI:
			begin
				if (queue_active)
					next_addr = `ASR_ADDR_X_HI; // Stay on the drain pointer
				else if (fast_read)
					next_addr = `ASR_ADDR_Y_HI; // Skip low byte
			end
			`ASR_ADDR_X_LO:
			begin
				if (fast_read)
					next_addr = `ASR_ADDR_STATUS;
			end
			`ASR_ADDR_Y_HI:
			begin
				if (fast_read && queue_active)
					next_addr = `ASR_ADDR_STATUS;
				else if (fast_read)
					next_addr = `ASR_ADDR_Z_HI;
			end
			`ASR_ADDR_Y_LO:
			begin
				if (fast_read)
					next_addr = `ASR_ADDR_STATUS;
			end
			`ASR_ADDR_Z_HI:
			begin
				if (fast_read)
					next_addr = `ASR_ADDR_STATUS;
			end
			`ASR_ADDR_Z_LO:
				next_addr = `ASR_ADDR_STATUS; // Last sample byte wraps
			default:
				next_addr = cur_addr + 8'h01;
		endcase
	end

endmodule // asr_next_addr

`default_nettype wire

// ===== hw/asr_reg_map.v
// Two-wire slave port and sample/status/queue-setup register map
`timescale 1ns/1ns
`default_nettype none
`include "asr_regs.vh"

module asr_reg_map (
	input wire clock,
	input wire sys_rst,
	input wire clk_en,
	input wire scl_in,
	input wire sda_in,
	output reg sda_out,
	output reg sda_oe_n,
	input wire address_select_input,
	input wire fast_read_enable,
	input wire [13:0] x_sample,
	input wire [13:0] y_sample,
	input wire [13:0] z_sample,
	input wire [7:0] sample_status,
	input wire [7:0] queue_status,
	output reg [7:0] queue_setup,
	output reg [7:0] capture_trigger_map,
	output reg [1:0] queue_operating_mode
);

	// ------------------------------------------------------------------------
	// States and byte kinds
	// ------------------------------------------------------------------------
	localparam [4:0] ST_IDLE = 5'b00001;
	localparam [4:0] ST_RX = 5'b00010;
	localparam [4:0] ST_ACK = 5'b00100;
	localparam [4:0] ST_TX = 5'b01000;
	localparam [4:0] ST_RACK = 5'b10000;

	localparam [2:0] KIND_DEV = 3'b001;
	localparam [2:0] KIND_REG = 3'b010;
	localparam [2:0] KIND_DATA = 3'b100;

	// ------------------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------------------
	wire [2:0] pins_s;
	wire scl_s;
	wire sda_s;
	wire asel_s;
	wire scl_rise;
	wire scl_fall;
	wire bus_start;
	wire bus_stop;
	wire queue_active;
	wire [7:0] ptr_next;
	wire [6:0] own_addr;
	reg scl_p_r;
	reg sda_p_r;
	reg [4:0] state_r;
	reg [2:0] kind_r;
	reg [3:0] bitcnt_r;
	reg [7:0] shift_r;
	reg [7:0] tx_r;
	reg [7:0] ptr_r;
	reg rw_r;
	reg [7:0] rdata;

	// ------------------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------------------
	// Bus lines and the address strap are asynchronous to our clock
	asr_sync2 #(
		.W(3)
	) u_sync (
		.clock(clock),
		.sys_rst(sys_rst),
		.clk_en(clk_en),
		.async_in({address_select_input, sda_in, scl_in}),
		.sync_out(pins_s)
	);

	assign scl_s = pins_s[0];
	assign sda_s = pins_s[1];
	assign asel_s = pins_s[2];

	// Edge and condition detection on synchronised lines only
	assign scl_rise = scl_s & ~scl_p_r;
	assign scl_fall = ~scl_s & scl_p_r;
	assign bus_start = scl_s & scl_p_r & sda_p_r & ~sda_s;
	assign bus_stop = scl_s & scl_p_r & ~sda_p_r & sda_s;

	// Strap picks the low address bit
	assign own_addr = {`ASR_SLAVE_BASE, asel_s};

	// Queue mode lives in the top two bits of the queue setup register
	assign queue_active = (queue_setup[`ASR_QMODE_HI:`ASR_QMODE_LO] != 2'b00);

	// ------------------------------------------------------------------------
	// Auto-increment target
	// ------------------------------------------------------------------------
	asr_next_addr u_next (
		.cur_addr(ptr_r),
		.queue_active(queue_active),
		.fast_read(fast_read_enable),
		.next_addr(ptr_next)
	);

	// ------------------------------------------------------------------------
	// Read data multiplexer
	// ------------------------------------------------------------------------
	// Samples come from logic on this clock, so they are read directly
	always @*
	begin
		rdata = `ASR_READ_ZERO;
		case (ptr_r)
			`ASR_ADDR_STATUS:
				rdata = queue_active ? queue_status : sample_status;
			`ASR_ADDR_X_HI:
				rdata = x_sample[`ASR_SAMPLE_HI_MSB:`ASR_SAMPLE_HI_LSB];
			`ASR_ADDR_X_LO:
				rdata = {x_sample[`ASR_SAMPLE_LO_MSB:`ASR_SAMPLE_LO_LSB], `ASR_LO_PAD};
			`ASR_ADDR_Y_HI:
				rdata = y_sample[`ASR_SAMPLE_HI_MSB:`ASR_SAMPLE_HI_LSB];
			`ASR_ADDR_Y_LO:
				rdata = {y_sample[`ASR_SAMPLE_LO_MSB:`ASR_SAMPLE_LO_LSB], `ASR_LO_PAD};
			`ASR_ADDR_Z_HI:
				rdata = z_sample[`ASR_SAMPLE_HI_MSB:`ASR_SAMPLE_HI_LSB];
			`ASR_ADDR_Z_LO:
				rdata = {z_sample[`ASR_SAMPLE_LO_MSB:`ASR_SAMPLE_LO_LSB], `ASR_LO_PAD};
			`ASR_ADDR_RSVD_A:
				rdata = `ASR_READ_ZERO;
			`ASR_ADDR_RSVD_B:
				rdata = `ASR_READ_ZERO;
			`ASR_ADDR_QUEUE_SETUP:
				rdata = queue_setup;
			`ASR_ADDR_TRIG_MAP:
				rdata = capture_trigger_map;
			default:
				rdata = `ASR_READ_ZERO; // Unmapped offsets read zero
		endcase
	end

	// ------------------------------------------------------------------------
	// Line history for edge detection
	// ------------------------------------------------------------------------
	always @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			scl_p_r <= 1'b1;
			sda_p_r <= 1'b1;
		end
		else if (clk_en)
		begin
			scl_p_r <= scl_s;
			sda_p_r <= sda_s;
		end
	end

	// ------------------------------------------------------------------------
	// Bus protocol engine
	// ------------------------------------------------------------------------
	// Start and stop win over any clock edge seen in the same cycle. The data
	// line only ever changes just after a clock fall, so it is stable while
	// the clock is high, as the bus requires.
	always @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			state_r <= ST_IDLE;
			kind_r <= KIND_DEV;
			bitcnt_r <= 4'h0;
			shift_r <= 8'h00;
			tx_r <= 8'h00;
			ptr_r <= `ASR_RST_PTR;
			rw_r <= 1'b0;
			sda_out <= 1'b0;
			sda_oe_n <= 1'b1;
			queue_setup <= `ASR_RST_QUEUE_SETUP;
			capture_trigger_map <= `ASR_RST_TRIG_MAP;
		end
		else if (clk_en)
		begin
			sda_out <= 1'b0; // Open drain: only ever pulls low
			if (bus_start)
			begin
				// Start or repeated start keeps the pointer for random reads
				state_r <= ST_RX;
				kind_r <= KIND_DEV;
				bitcnt_r <= 4'h0;
				sda_oe_n <= 1'b1;
			end
			else if (bus_stop)
			begin
				state_r <= ST_IDLE;
				sda_oe_n <= 1'b1;
			end
			else
			begin
				case (state_r)
					ST_IDLE:
						sda_oe_n <= 1'b1;
					ST_RX:
					begin
						if (scl_rise)
						begin
							shift_r <= {shift_r[6:0], sda_s};
							bitcnt_r <= bitcnt_r + 4'h1;
						end
						else if (scl_fall && bitcnt_r == `ASR_BITS_PER_BYTE)
						begin
							bitcnt_r <= 4'h0;
							if (kind_r == KIND_DEV)
							begin
								if (shift_r[7:1] == own_addr)
								begin
									rw_r <= shift_r[0];
									state_r <= ST_ACK;
									sda_oe_n <= 1'b0; // Acknowledge address
								end
								else
									state_r <= ST_IDLE; // Not ours: stay off the bus
							end
							else if (kind_r == KIND_REG)
							begin
								ptr_r <= shift_r;
								state_r <= ST_ACK;
								sda_oe_n <= 1'b0;
							end
							else
							begin
								// Writes to read-only or reserved offsets are dropped
								if (ptr_r == `ASR_ADDR_QUEUE_SETUP)
									queue_setup <= shift_r;
								if (ptr_r == `ASR_ADDR_TRIG_MAP)
									capture_trigger_map <= shift_r;
								ptr_r <= ptr_next; // Burst write advance
								state_r <= ST_ACK;
								sda_oe_n <= 1'b0;
							end
						end
					end
					ST_ACK:
					begin
						// Hold low through the ninth clock high; on its fall let go, or for a read drive the first data bit
						if (scl_fall)
						begin
							if (kind_r == KIND_DEV && rw_r)
							begin
								tx_r <= rdata;
								sda_oe_n <= rdata[7];
								state_r <= ST_TX;
							end
							else
							begin
								sda_oe_n <= 1'b1;
								state_r <= ST_RX;
								kind_r <= (kind_r == KIND_DEV) ? KIND_REG : KIND_DATA;
							end
						end
					end
					ST_TX:
					begin
						if (scl_fall)
						begin
							if (bitcnt_r == `ASR_LAST_TX_BIT)
							begin
								bitcnt_r <= 4'h0;
								sda_oe_n <= 1'b1; // Release for host acknowledge
								state_r <= ST_RACK;
							end
							else
							begin
								bitcnt_r <= bitcnt_r + 4'h1;
								tx_r <= {tx_r[6:0], 1'b0};
								sda_oe_n <= tx_r[6]; // MSB first, one released = one
							end
						end
					end
					ST_RACK:
					begin
						if (scl_rise && !sda_s)
							ptr_r <= ptr_next; // Host acknowledged: advance
						else if (scl_rise)
							state_r <= ST_IDLE; // Host NAK ends the read
						else if (scl_fall)
						begin
							// Pointer already advanced on the rise, so fetch from it
							tx_r <= rdata;
							sda_oe_n <= rdata[7];
							state_r <= ST_TX;
						end
					end
					default:
					begin
						state_r <= ST_IDLE;
						sda_oe_n <= 1'b1;
					end
				endcase
			end
		end
	end

	// ------------------------------------------------------------------------
	// Mode output
	// ------------------------------------------------------------------------
	// Registered copy of the queue mode for the capture logic downstream
	always @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
			queue_operating_mode <= 2'b00;
		else if (clk_en)
			queue_operating_mode <= queue_setup[`ASR_QMODE_HI:`ASR_QMODE_LO];
	end

endmodule // asr_reg_map

`default_nettype wire

// ===== hw/asr_regs.vh
// Register offsets, field positions, reset values and bus constants of the sample register map
`ifndef ASR_REGS_VH
`define ASR_REGS_VH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define ASR_ADDR_STATUS 8'h00
`define ASR_ADDR_X_HI 8'h01
`define ASR_ADDR_X_LO 8'h02
`define ASR_ADDR_Y_HI 8'h03
`define ASR_ADDR_Y_LO 8'h04
`define ASR_ADDR_Z_HI 8'h05
`define ASR_ADDR_Z_LO 8'h06
`define ASR_ADDR_RSVD_A 8'h07
`define ASR_ADDR_RSVD_B 8'h08
`define ASR_ADDR_QUEUE_SETUP 8'h09
`define ASR_ADDR_TRIG_MAP 8'h0a

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define ASR_RST_QUEUE_SETUP 8'h00
`define ASR_RST_TRIG_MAP 8'h00
`define ASR_RST_PTR 8'h00
`define ASR_READ_ZERO 8'h00

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define ASR_QMODE_HI 7
`define ASR_QMODE_LO 6
`define ASR_SAMPLE_HI_MSB 13
`define ASR_SAMPLE_HI_LSB 6
`define ASR_SAMPLE_LO_MSB 5
`define ASR_SAMPLE_LO_LSB 0
`define ASR_LO_PAD 2'b00

// ----------------------------------------------------------------------------
// Two-wire bus constants
// ----------------------------------------------------------------------------
`define ASR_SLAVE_BASE 6'b001110
`define ASR_BITS_PER_BYTE 4'h8
`define ASR_LAST_TX_BIT 4'h7

`endif

// ===== hw/asr_sync2.v
// Two-flop synchroniser for pin inputs, frozen by the clock enable
`timescale 1ns/1ns
`default_nettype none

module asr_sync2 #(
	parameter W = 3
) (
	input wire clock,
	input wire sys_rst,
	input wire clk_en,
	input wire [W-1:0] async_in,
	output reg [W-1:0] sync_out
);

	reg [W-1:0] meta_r;

	// First stage feeds only the second; idle bus lines read high after reset
	always @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			meta_r <= {W{1'b1}};
			sync_out <= {W{1'b1}};
		end
		else if (clk_en)
		begin
			meta_r <= async_in;
			sync_out <= meta_r;
		end
	end

endmodule // asr_sync2

`default_nettype wire
